//--- src/accumulator_alu_with_flags.sv
`timescale 1ns/100ps
module accumulator_alu_with_flags #(
    parameter int DATA_W = alu_pkg::DATA_W,
    parameter int PC_W = alu_pkg::PC_W,
    parameter int RAM_AW = alu_pkg::RAM_AW
) (
    // Clock and reset.
    input wire logic ref_clk_i,
    input wire logic rst_i,
    // Decoder side.
    input wire alu_pkg::instr_t instr_i,
    output logic ready_o,
    output logic [PC_W-1:0] pc_o,
    output alu_pkg::flags_t flags_o,
    // Measurement results, latched at measurement end only in S_IDLE with no result drain running.
    input wire logic meas_done_i,
    input wire logic [16*DATA_W-1:0] results_i,
    input wire alu_pkg::status_in_t status_i,
    // RAM side, read data arrives one cycle after the address.
    output alu_pkg::ram_req_t ram_o,
    input wire logic [DATA_W-1:0] ram_rdata_i
);

    // ==========================================================
    // State.
    // ==========================================================
    typedef struct packed {
        alu_pkg::phase_t phase;
        logic [DATA_W-1:0] acc_x;
        logic [DATA_W-1:0] acc_y;
        logic [DATA_W-1:0] acc_z;
        alu_pkg::flags_t flags;
        logic [RAM_AW-1:0] ptr;
        logic [PC_W-1:0] pc;
        logic [PC_W-1:0] ret_pc;
        alu_pkg::instr_t cur;
        alu_pkg::ram_req_t ram;
        logic [3:0] res_idx;
        logic res_busy;
        logic [16*DATA_W-1:0] res_buf;
    } state_t;

    state_t state_reg;
    state_t state_next;

    logic [DATA_W-1:0] opa;
    logic [DATA_W-1:0] opb;
    logic [DATA_W-1:0] res;
    logic [DATA_W-1:0] res2;
    logic wr2;
    logic calc;
    logic cout;
    logic vout;
    logic cond_hit;
    logic [DATA_W-1:0] status_word;

    // ==========================================================
    // Operand selection.
    // ==========================================================
    function automatic logic [DATA_W-1:0] pick(input alu_pkg::acc_sel_t s, input state_t st,
                                               input logic [DATA_W-1:0] rd);
        logic [DATA_W-1:0] v;
        case (s)
            alu_pkg::ACC_X: v = st.acc_x;
            alu_pkg::ACC_Y: v = st.acc_y;
            alu_pkg::ACC_Z: v = st.acc_z;
            alu_pkg::ACC_R: v = rd;
            default: v = st.acc_x;
        endcase
        return v;
    endfunction

    always_comb begin
        opa = pick(state_reg.cur.dst, state_reg, ram_rdata_i);
        opb = state_reg.cur.use_imm ? state_reg.cur.imm : pick(state_reg.cur.src, state_reg, ram_rdata_i);
    end

    alu_core #(
        .W(DATA_W)
    ) u_core (
        .op_i(state_reg.cur.op),
        .a_i(opa),
        .b_i(opb),
        .carry_in_i(state_reg.flags.carry),
        .result_o(res),
        .second_o(res2),
        .writes_second_o(wr2),
        .calc_o(calc),
        .carry_o(cout),
        .overflow_o(vout)
    );

    // ==========================================================
    // Status word assembly.
    // ==========================================================
    always_comb begin
        status_word = '0;
        status_word[alu_pkg::ST_CPORT_STATE_LSB +: 4] = status_i.cport_state;
        status_word[alu_pkg::ST_CAUSE_LSB +: 5] = status_i.entry_cause;
        status_word[alu_pkg::ST_LOW_SUPPLY] = status_i.low_supply_flag;
        status_word[alu_pkg::ST_CONV_ERR] = status_i.conv_error;
        status_word[alu_pkg::ST_CPORT_ERR] = status_i.cport_error;
        status_word[alu_pkg::ST_STRAIN_ERR] = status_i.strain_error;
        status_word[alu_pkg::ST_CONV_TIMEOUT] = status_i.conv_timeout;
        status_word[alu_pkg::ST_EXT_START] = status_i.ext_start;
        status_word[alu_pkg::ST_RISE_LSB +: 4] = status_i.cport_rise;
        status_word[alu_pkg::ST_FALL_LSB +: 4] = status_i.cport_fall;
    end

    // ==========================================================
    // Condition evaluation.
    // ==========================================================
    always_comb begin
        case (state_reg.cur.cond)
            alu_pkg::COND_CARRY: cond_hit = state_reg.flags.carry;
            alu_pkg::COND_NOT_EQUAL: cond_hit = state_reg.flags.not_equal;
            alu_pkg::COND_SIGN: cond_hit = state_reg.flags.sign;
            alu_pkg::COND_OVERFLOW: cond_hit = state_reg.flags.overflow;
            default: cond_hit = 1'b1;
        endcase
        if (state_reg.cur.cond != alu_pkg::COND_ALWAYS && state_reg.cur.cond_invert) begin
            cond_hit = ~cond_hit;
        end
    end

    // ==========================================================
    // Next-state logic.
    // ==========================================================
    always_comb begin
        logic [DATA_W-1:0] wv;
        logic [PC_W-1:0] seq_pc;
        logic [3:0] sb;
        wv = '0;
        sb = '0;
        state_next = state_reg;
        state_next.ram.we = 1'b0;
        seq_pc = state_reg.pc + PC_W'(state_reg.cur.length);
        // Result writes steal the RAM port, so instructions wait while the block of sixteen drains.
        if (state_reg.res_busy && state_reg.phase == alu_pkg::S_IDLE) begin
            state_next.ram.we = 1'b1;
            state_next.ram.addr = alu_pkg::RESULT_BASE + RAM_AW'(state_reg.res_idx);
            state_next.ram.wdata = state_reg.res_buf[state_reg.res_idx*DATA_W +: DATA_W];
            state_next.res_idx = state_reg.res_idx + 4'h1;
            state_next.res_busy = (state_reg.res_idx != 4'hF);
        end else if (meas_done_i && !state_reg.res_busy && state_reg.phase == alu_pkg::S_IDLE) begin
            state_next.res_buf = results_i;
            state_next.res_buf[6*DATA_W +: DATA_W] = status_word;
            state_next.res_idx = 4'h0;
            state_next.res_busy = 1'b1;
        end else begin
            case (state_reg.phase)
                alu_pkg::S_IDLE: begin
                    if (instr_i.valid) begin
                        state_next.cur = instr_i;
                        state_next.ram.addr = state_reg.ptr;
                        state_next.phase = alu_pkg::S_READ;
                    end
                end
                alu_pkg::S_READ: begin
                    state_next.phase = alu_pkg::S_EXEC;
                end
                alu_pkg::S_EXEC: begin
                    state_next.phase = alu_pkg::S_IDLE;
                    state_next.pc = seq_pc;
                    if (state_reg.cur.op != alu_pkg::OP_NOP) begin
                        wv = res;
                        state_next.flags.not_equal = (wv == '0);
                        state_next.flags.sign = wv[DATA_W-1];
                        if (calc) begin
                            state_next.flags.carry = cout;
                            state_next.flags.overflow = vout;
                        end
                        case (state_reg.cur.dst)
                            alu_pkg::ACC_X: state_next.acc_x = wv;
                            alu_pkg::ACC_Y: state_next.acc_y = wv;
                            alu_pkg::ACC_Z: state_next.acc_z = wv;
                            default: begin
                                state_next.ram.we = 1'b1;
                                state_next.ram.addr = state_reg.ptr;
                                state_next.ram.wdata = wv;
                            end
                        endcase
                        if (wr2 && !state_reg.cur.use_imm) begin
                            case (state_reg.cur.src)
                                alu_pkg::ACC_X: state_next.acc_x = res2;
                                alu_pkg::ACC_Y: state_next.acc_y = res2;
                                alu_pkg::ACC_Z: state_next.acc_z = res2;
                                default: begin
                                    state_next.cur.dst = alu_pkg::ACC_R;
                                    state_next.cur.imm = res2;
                                    state_next.phase = alu_pkg::S_STORE;
                                end
                            endcase
                        end
                    end
                    // Pointer moves only reselect the fourth accumulator; RAM is not written.
                    case (state_reg.cur.ptr_op)
                        alu_pkg::PTR_LOAD: state_next.ptr = state_reg.cur.ptr_value;
                        alu_pkg::PTR_INC: state_next.ptr = state_reg.ptr + RAM_AW'(1);
                        alu_pkg::PTR_DEC: state_next.ptr = state_reg.ptr - RAM_AW'(1);
                        default: state_next.ptr = state_reg.ptr;
                    endcase
                    case (state_reg.cur.jump)
                        alu_pkg::JMP_ABS: begin
                            if (cond_hit) begin
                                state_next.pc = state_reg.cur.target;
                            end
                        end
                        alu_pkg::JMP_REL: begin
                            if (cond_hit) begin
                                state_next.pc = state_reg.pc + PC_W'({{(PC_W-8){state_reg.cur.disp[7]}},
                                    state_reg.cur.disp});
                            end
                        end
                        alu_pkg::JMP_SKIP: begin
                            sb = state_reg.cur.skip_bytes;
                            if (cond_hit && state_reg.cur.skip_ops != 2'd0 && sb >= 4'(alu_pkg::SKIP_MIN_BYTES)
                                && 32'(sb) <= alu_pkg::SKIP_MAX_BYTES) begin
                                state_next.pc = seq_pc + PC_W'(sb);
                            end
                        end
                        alu_pkg::JMP_CALL: begin
                            state_next.ret_pc = seq_pc;
                            state_next.pc = state_reg.cur.target;
                        end
                        alu_pkg::JMP_RET: begin
                            state_next.pc = state_reg.ret_pc;
                        end
                        default: begin
                        end
                    endcase
                end
                alu_pkg::S_STORE: begin
                    // Second half of a swap whose source is the RAM word.
                    state_next.ram.we = 1'b1;
                    state_next.ram.addr = state_reg.ptr;
                    state_next.ram.wdata = state_reg.cur.imm;
                    state_next.phase = alu_pkg::S_IDLE;
                end
                default: begin
                    state_next.phase = alu_pkg::S_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            state_reg <= '0;
            state_reg.phase <= alu_pkg::S_IDLE;
            state_reg.pc <= alu_pkg::PC_RESET;
            state_reg.ptr <= alu_pkg::PTR_RESET;
            state_reg.acc_x <= alu_pkg::ACC_RESET;
            state_reg.acc_y <= alu_pkg::ACC_RESET;
            state_reg.acc_z <= alu_pkg::ACC_RESET;
        end else begin
            state_reg <= state_next;
        end
    end

    // ==========================================================
    // Outputs.
    // ==========================================================
    assign ready_o = (state_reg.phase == alu_pkg::S_IDLE) && !state_reg.res_busy && !meas_done_i;
    assign pc_o = state_reg.pc;
    assign flags_o = state_reg.flags;
    assign ram_o = state_reg.ram;

endmodule // accumulator_alu_with_flags

//--- shared/alu_pkg.sv
package alu_pkg;

    // ==========================================================
    // Widths and address map.
    // ==========================================================
    localparam int DATA_W = 24;
    localparam int RAM_AW = 8;
    localparam int PC_W = 13;
    localparam logic [7:0] RESULT_BASE = 8'hF0;
    localparam logic [7:0] LEGACY_SHIFT = 8'hE0;
    localparam logic [7:0] ADDR_BRIDGE1 = 8'hF0;
    localparam logic [7:0] ADDR_BRIDGE2 = 8'hF1;
    localparam logic [7:0] ADDR_BRIDGE3 = 8'hF2;
    localparam logic [7:0] ADDR_BRIDGE4 = 8'hF3;
    localparam logic [7:0] ADDR_COMP_SUM = 8'hF4;
    localparam logic [7:0] ADDR_TEMP = 8'hF5;
    localparam logic [7:0] ADDR_STATUS = 8'hF6;
    localparam logic [7:0] ADDR_GAUGE_TIME = 8'hF7;
    localparam logic [7:0] ADDR_RESOLUTION = 8'hF8;
    localparam logic [7:0] ADDR_SUPPLY = 8'hF9;
    localparam logic [7:0] ADDR_KEY_FALL = 8'hFA;
    localparam logic [7:0] ADDR_KEY_RISE = 8'hFB;
    localparam logic [7:0] ADDR_KEY_PRESS = 8'hFC;
    localparam logic [7:0] ADDR_GPIO = 8'hFD;
    localparam logic [7:0] ADDR_TIMER = 8'hFE;
    localparam logic [7:0] ADDR_SPAN = 8'hFF;

    // ==========================================================
    // Status word field positions.
    // ==========================================================
    localparam int ST_CPORT_STATE_LSB = 20;
    localparam int ST_CAUSE_LSB = 15;
    localparam int ST_LOW_SUPPLY = 14;
    localparam int ST_CONV_ERR = 13;
    localparam int ST_CPORT_ERR = 11;
    localparam int ST_STRAIN_ERR = 10;
    localparam int ST_CONV_TIMEOUT = 9;
    localparam int ST_EXT_START = 8;
    localparam int ST_RISE_LSB = 4;
    localparam int ST_FALL_LSB = 0;

    // ==========================================================
    // Sequencer limits and reset values.
    // ==========================================================
    localparam int SKIP_MAX_OPS = 3;
    localparam int SKIP_MIN_BYTES = 3;
    localparam int SKIP_MAX_BYTES = 15;
    localparam logic [PC_W-1:0] PC_RESET = 13'h0000;
    localparam logic [RAM_AW-1:0] PTR_RESET = 8'h00;
    localparam logic [DATA_W-1:0] ACC_RESET = 24'h000000;

    // ==========================================================
    // Accumulator selection and operations.
    // ==========================================================
    typedef enum logic [1:0] {ACC_X, ACC_Y, ACC_Z, ACC_R} acc_sel_t;

    typedef enum logic [3:0] {
        OP_NOP, OP_MOVE, OP_SWAP, OP_ADD, OP_SUB, OP_SHIFT_R, OP_SHIFT_L,
        OP_ROT_R, OP_ROT_L, OP_MULT, OP_AND, OP_OR, OP_XOR, OP_LOAD_IMM
    } alu_op_t;

    typedef enum logic [2:0] {
        JMP_NONE, JMP_ABS, JMP_REL, JMP_SKIP, JMP_CALL, JMP_RET
    } jump_kind_t;

    typedef enum logic [2:0] {
        COND_ALWAYS, COND_CARRY, COND_NOT_EQUAL, COND_SIGN, COND_OVERFLOW
    } cond_sel_t;

    typedef enum logic [1:0] {PTR_KEEP, PTR_LOAD, PTR_INC, PTR_DEC} ptr_op_t;

    typedef enum logic [1:0] {S_IDLE, S_READ, S_EXEC, S_STORE} phase_t;

    typedef struct packed {
        logic carry;
        logic not_equal;
        logic sign;
        logic overflow;
    } flags_t;

    typedef struct packed {
        logic valid;
        alu_op_t op;
        acc_sel_t dst;
        acc_sel_t src;
        logic use_imm;
        logic [DATA_W-1:0] imm;
        ptr_op_t ptr_op;
        logic [RAM_AW-1:0] ptr_value;
        jump_kind_t jump;
        cond_sel_t cond;
        logic cond_invert;
        logic [PC_W-1:0] target;
        logic [7:0] disp;
        logic [1:0] skip_ops;
        logic [3:0] skip_bytes;
        logic [2:0] length;
    } instr_t;

    typedef struct packed {
        logic [3:0] cport_state;
        logic [4:0] entry_cause;
        logic low_supply_flag;
        logic conv_error;
        logic cport_error;
        logic strain_error;
        logic conv_timeout;
        logic ext_start;
        logic [3:0] cport_rise;
        logic [3:0] cport_fall;
    } status_in_t;

    typedef struct packed {
        logic we;
        logic [RAM_AW-1:0] addr;
        logic [DATA_W-1:0] wdata;
    } ram_req_t;

endpackage

//--- src/alu_core.sv
`timescale 1ns/100ps
module alu_core #(
    parameter int W = 24
) (
    // Operation and operands.
    input wire alu_pkg::alu_op_t op_i,
    input wire logic [W-1:0] a_i,
    input wire logic [W-1:0] b_i,
    input wire logic carry_in_i,
    // Result.
    output logic [W-1:0] result_o,
    output logic [W-1:0] second_o,
    output logic writes_second_o,
    output logic calc_o,
    output logic carry_o,
    output logic overflow_o
);
    logic [W:0] wide;
    logic [2*W-1:0] prod;

    always_comb begin
        wide = '0;
        prod = a_i * b_i;
        result_o = a_i;
        second_o = b_i;
        writes_second_o = 1'b0;
        calc_o = 1'b0;
        carry_o = carry_in_i;
        overflow_o = 1'b0;
        case (op_i)
            alu_pkg::OP_MOVE, alu_pkg::OP_LOAD_IMM: begin
                result_o = b_i;
            end
            alu_pkg::OP_SWAP: begin
                result_o = b_i;
                second_o = a_i;
                writes_second_o = 1'b1;
            end
            alu_pkg::OP_ADD: begin
                wide = {1'b0, a_i} + {1'b0, b_i};
                result_o = wide[W-1:0];
                calc_o = 1'b1;
                carry_o = wide[W];
                overflow_o = (a_i[W-1] == b_i[W-1]) && (wide[W-1] != a_i[W-1]);
            end
            alu_pkg::OP_SUB: begin
                wide = {1'b0, a_i} - {1'b0, b_i};
                result_o = wide[W-1:0];
                calc_o = 1'b1;
                carry_o = wide[W];
                overflow_o = (a_i[W-1] != b_i[W-1]) && (wide[W-1] != a_i[W-1]);
            end
            alu_pkg::OP_SHIFT_R: begin
                result_o = {a_i[W-1], a_i[W-1:1]};
                calc_o = 1'b1;
                carry_o = a_i[0];
            end
            alu_pkg::OP_SHIFT_L: begin
                result_o = {a_i[W-2:0], 1'b0};
                calc_o = 1'b1;
                carry_o = a_i[W-1];
            end
            alu_pkg::OP_ROT_R: begin
                result_o = {carry_in_i, a_i[W-1:1]};
                calc_o = 1'b1;
                carry_o = a_i[0];
            end
            alu_pkg::OP_ROT_L: begin
                result_o = {a_i[W-2:0], carry_in_i};
                calc_o = 1'b1;
                carry_o = a_i[W-1];
            end
            alu_pkg::OP_MULT: begin
                result_o = prod[W-1:0];
                calc_o = 1'b1;
            end
            alu_pkg::OP_AND: begin
                result_o = a_i & b_i;
            end
            alu_pkg::OP_OR: begin
                result_o = a_i | b_i;
            end
            alu_pkg::OP_XOR: begin
                result_o = a_i ^ b_i;
            end
            default: begin
                result_o = a_i;
            end
        endcase
    end
endmodule // alu_core

//--- verification/alu_ram_model.sv
`timescale 1ns/100ps
// ============================================
// Word RAM on the far side.
// ============================================
module alu_ram_model (
    // Clock.
    input wire logic ref_clk_i,
    // Request and read data.
    input wire alu_pkg::ram_req_t ram_i,
    output logic [23:0] rdata_o
);
    logic [23:0] mem [256];
    // Words start at zero so that arithmetic on unwritten words stays defined.
    initial foreach (mem[a]) mem[a] = 24'h000000;
    always @(posedge ref_clk_i) begin
        if (ram_i.we) mem[ram_i.addr] <= ram_i.wdata;
        rdata_o <= mem[ram_i.addr];
    end
endmodule // alu_ram_model

//--- verification/accumulator_alu_with_flags_asserts.sv
`timescale 1ns/100ps
// ============================================
// Port checker.
// ============================================
module alu_flags_checker (
    // Clock and reset.
    input wire logic ref_clk_i,
    input wire logic rst_i,
    // Watched ports.
    input wire alu_pkg::instr_t instr_i,
    input wire logic ready_o,
    input wire alu_pkg::flags_t flags_o,
    input wire logic meas_done_i,
    input wire alu_pkg::ram_req_t ram_o
);
    default clocking @(posedge ref_clk_i); endclocking
    default disable iff (rst_i);
    meas_first_a: assert property ($rose(meas_done_i) && $past(ready_o)
        |-> ##2 ram_o.we && ram_o.addr == 8'hF0)
        else $error("result drain did not start at F0");
    meas_burst_a: assert property ($rose(meas_done_i) && $past(ready_o) |-> ##2 ram_o.we [*8])
        else $error("result drain not back to back");
    meas_last_a: assert property ($rose(meas_done_i) && $past(ready_o)
        |-> ##17 ram_o.we && ram_o.addr == 8'hFF)
        else $error("result drain did not end at FF");
    take_busy_a: assert property (instr_i.valid && ready_o |=> !ready_o)
        else $error("ready stayed high after take");
    ready_back_a: assert property (instr_i.valid && ready_o |-> ##[1:6] ready_o)
        else $error("instruction never completed");
    // The second write of a swap with the RAM word carries the old first operand, so it is left out.
    ne_flag_a: assert property (ram_o.we && ready_o && !$past(ram_o.we) && $past(ready_o, 3)
        |-> flags_o.not_equal == (ram_o.wdata == 24'h0))
        else $error("not equal flag wrong on ram write");
    sign_flag_a: assert property (ram_o.we && ready_o && !$past(ram_o.we) && $past(ready_o, 3)
        |-> flags_o.sign == ram_o.wdata[23])
        else $error("sign flag wrong on ram write");
    ptr_nowrite_a: assert property (instr_i.valid && ready_o && instr_i.op == alu_pkg::OP_NOP && !meas_done_i
        |=> !ram_o.we [*4])
        else $error("pointer change wrote ram");
endmodule // alu_flags_checker

bind accumulator_alu_with_flags alu_flags_checker chk_u (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .instr_i(instr_i),
    .ready_o(ready_o), .flags_o(flags_o), .meas_done_i(meas_done_i), .ram_o(ram_o));

//--- verification/test_accumulator_alu_with_flags.sv
`timescale 1ns/100ps
// ============================================
// Bench.
// ============================================
module test_accumulator_alu_with_flags;
    logic ref_clk_i = 1'b0, rst_i = 1'b1, ready_o, meas_done_i = 1'b0;
    logic [12:0] pc_o;
    logic [23:0] rdata;
    logic [383:0] results_i = '0;
    alu_pkg::instr_t instr_i = '0, ins;
    alu_pkg::flags_t flags_o;
    alu_pkg::status_in_t status_i = '0;
    alu_pkg::ram_req_t ram_o;
    int n_errors = 0, total_checks = 0, cycles = 0;
    accumulator_alu_with_flags dut_u (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .instr_i(instr_i), .ready_o(ready_o),
        .pc_o(pc_o), .flags_o(flags_o), .meas_done_i(meas_done_i), .results_i(results_i), .status_i(status_i),
        .ram_o(ram_o), .ram_rdata_i(rdata));
    alu_ram_model ram_u (.ref_clk_i(ref_clk_i), .ram_i(ram_o), .rdata_o(rdata));
    initial forever #10 ref_clk_i = ~ref_clk_i;
    // A hang anywhere ends the run through the same report.
    always @(posedge ref_clk_i) begin
        cycles++;
        if (cycles == 3000) begin
            n_errors++;
            results();
        end
    end
    task automatic results();
        $display("checks=%0d errors=%0d", total_checks, n_errors);
        if (n_errors == 0 && total_checks > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    task automatic chk(input logic [23:0] seen, input logic [23:0] exp);
        total_checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic go();
        int k = 0;
        @(posedge ref_clk_i);
        #1 instr_i = ins;
        // Ready is looked at between edges, so the edge that takes the request is known in advance.
        while (ready_o !== 1'b1 && k < 20) begin
            @(posedge ref_clk_i);
            #1;
            k++;
        end
        @(posedge ref_clk_i);
        #1 instr_i.valid = 1'b0;
        do begin @(posedge ref_clk_i); #1; k++; end while (ready_o !== 1'b1 && k < 40);
    endtask
    task automatic base();
        ins = '0;
        ins.valid = 1'b1;
        ins.length = 3'h1;
    endtask
    task automatic op(input alu_pkg::alu_op_t o, input alu_pkg::acc_sel_t d, s, input logic [23:0] v);
        base();
        ins.op = o;
        ins.dst = d;
        ins.src = s;
        ins.use_imm = (o != alu_pkg::OP_MOVE) && (s == alu_pkg::ACC_X);
        ins.imm = v;
        go();
    endtask
    task automatic ptr(input logic [7:0] a);
        base();
        ins.ptr_op = alu_pkg::PTR_LOAD;
        ins.ptr_value = a;
        go();
    endtask
    task automatic t_arith();
        op(alu_pkg::OP_LOAD_IMM, alu_pkg::ACC_X, alu_pkg::ACC_X, 24'h7FFFFF);
        op(alu_pkg::OP_ADD, alu_pkg::ACC_X, alu_pkg::ACC_X, 24'h000001);
        chk(24'(flags_o), 24'h000003);
        op(alu_pkg::OP_LOAD_IMM, alu_pkg::ACC_X, alu_pkg::ACC_X, 24'hFFFFFF);
        chk(24'(flags_o), 24'h000003);
        op(alu_pkg::OP_ADD, alu_pkg::ACC_X, alu_pkg::ACC_X, 24'h000001);
        chk(24'(flags_o), 24'h00000C);
        op(alu_pkg::OP_LOAD_IMM, alu_pkg::ACC_Y, alu_pkg::ACC_X, 24'h000000);
        op(alu_pkg::OP_SUB, alu_pkg::ACC_Y, alu_pkg::ACC_X, 24'h000001);
        chk(24'(flags_o), 24'h00000A);
    endtask
    task automatic t_ram_acc();
        ptr(8'h10);
        op(alu_pkg::OP_MOVE, alu_pkg::ACC_R, alu_pkg::ACC_Y, 24'h000000);
        @(posedge ref_clk_i);
        #1;
        chk(ram_u.mem[8'h10], 24'hFFFFFF);
        chk(24'(flags_o), 24'h00000A);
        op(alu_pkg::OP_ADD, alu_pkg::ACC_X, alu_pkg::ACC_R, 24'h000000);
        chk(24'(flags_o), 24'h000002);
        ptr(8'h11);
        chk(ram_u.mem[8'h10], 24'hFFFFFF);
        op(alu_pkg::OP_LOAD_IMM, alu_pkg::ACC_Z, alu_pkg::ACC_X, 24'h000001);
        op(alu_pkg::OP_SHIFT_R, alu_pkg::ACC_Z, alu_pkg::ACC_Z, 24'h000000);
        chk(24'({flags_o.carry, flags_o.not_equal}), 24'h000003);
        op(alu_pkg::OP_SWAP, alu_pkg::ACC_X, alu_pkg::ACC_R, 24'h000000);
        @(posedge ref_clk_i);
        #1;
        chk(ram_u.mem[8'h11], 24'hFFFFFF);
        chk(24'(flags_o), 24'h00000C);
    endtask
    task automatic t_jump();
        base();
        ins.jump = alu_pkg::JMP_ABS;
        ins.target = 13'h1FFF;
        go();
        chk(24'(pc_o), 24'h001FFF);
        ins.jump = alu_pkg::JMP_REL;
        ins.disp = 8'h80;
        go();
        chk(24'(pc_o), 24'h001F7F);
        ins.jump = alu_pkg::JMP_SKIP;
        ins.cond = alu_pkg::COND_CARRY;
        ins.skip_ops = 2'h3;
        ins.skip_bytes = 4'hF;
        go();
        chk(24'(pc_o), 24'h001F8F);
        ins.cond_invert = 1'b1;
        go();
        chk(24'(pc_o), 24'h001F90);
        // The condition still fails here, and the call must be taken all the same.
        ins.jump = alu_pkg::JMP_CALL;
        ins.target = 13'h0100;
        go();
        chk(24'(pc_o), 24'h000100);
        ins.jump = alu_pkg::JMP_RET;
        go();
        chk(24'(pc_o), 24'h001F91);
    endtask
    task automatic t_meas();
        for (int k = 0; k < 16; k++) results_i[k*24 +: 24] = 24'hA00000 + 24'(k);
        status_i = '1;
        @(posedge ref_clk_i);
        #1 meas_done_i = 1'b1;
        @(posedge ref_clk_i);
        #1 meas_done_i = 1'b0;
        repeat (20) @(posedge ref_clk_i);
        for (int k = 0; k < 16; k++) chk(ram_u.mem[8'hF0 + k], k == 6 ? 24'hFFEFFF : 24'hA00000 + 24'(k));
    endtask
    initial begin
        repeat (6) @(posedge ref_clk_i);
        #1 rst_i = 1'b0;
        t_arith();
        t_ram_acc();
        t_jump();
        t_meas();
        results();
    end
endmodule // test_accumulator_alu_with_flags
